// File: trf_map.vh
`ifndef TRF_MAP_VH
`define TRF_MAP_VH
// register byte addresses
`define TRF_ADDR_R1_VALUE 8'h25
`define TRF_ADDR_LC_VALUE 8'h26
`define TRF_ADDR_R2_VALUE 8'h27
`define TRF_ADDR_R1_LOW 8'h4e
`define TRF_ADDR_R1_HIGH 8'h4f
`define TRF_ADDR_LC_LOW 8'h50
`define TRF_ADDR_LC_HIGH 8'h51
`define TRF_ADDR_R2_LOW 8'h52
`define TRF_ADDR_R2_HIGH 8'h53
`define TRF_ADDR_R1_CORR 8'h70
`define TRF_ADDR_LC_CORR 8'h71
`define TRF_ADDR_R2_CORR 8'h72
`define TRF_ADDR_FRACTION 8'h77
`define TRF_ADDR_CONFIG5 8'h7c
// configuration register 5 field
`define TRF_CFG5_TWOS_BIT 1
// reset values
`define TRF_RST_VALUE 8'h01
`define TRF_RST_LOW 8'h01
`define TRF_RST_HIGH 8'h7f
`define TRF_RST_CORR 8'h00
`define TRF_RST_FRACTION 8'h00
`define TRF_RST_CONFIG5 8'h00
// fraction register field positions (lsb of each pair)
`define TRF_FRAC_R1_POS 2
`define TRF_FRAC_LC_POS 4
`define TRF_FRAC_R2_POS 6
// codes
`define TRF_FAULT_TWOS 8'h80
`define TRF_FAULT_OFF64 8'h00
`define TRF_OFF64_BIAS 12'h100
`define TRF_TWOS_FLOOR 12'hf04
`define TRF_TWOS_MIN 12'he00
`define TRF_TWOS_MAX 12'h1ff
`define TRF_OFF64_MAX 12'h3ff
`endif

// File: trf_regram.v
`include "trf_map.vh"

// small register store for limits and corrections, registered read port
module trf_regram (
    input wire clk_sys,
    input wire rst_n,
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [7:0] wr_data,
    input wire [3:0] rd_idx,
    output reg [7:0] rd_data,
    output wire [71:0] flat
);
    reg [7:0] mem [0:8];
    genvar gi;
    // entries 0..5 limits low/high pairs, 6..8 corrections
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_ent
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    if (gi >= 6) begin
                        mem[gi] <= `TRF_RST_CORR;
                    end else if (gi % 2 == 0) begin
                        mem[gi] <= `TRF_RST_LOW;
                    end else begin
                        mem[gi] <= `TRF_RST_HIGH;
                    end
                end else if (wr_en && wr_idx == gi) begin
                    mem[gi] <= wr_data;
                end
            end
            assign flat[gi*8 +: 8] = mem[gi];
        end
    endgenerate
    // registered read data
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_idx < 4'd9) begin
            rd_data <= mem[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // trf_regram

// File: trf_formatter.v
`include "trf_map.vh"

module trf_formatter (
    input wire clk_sys,
    input wire rst_n,
    input wire [1:0] meas_chan,
    input wire [9:0] meas_data,
    input wire meas_valid,
    input wire meas_fault,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg [2:0] limit_status,
    output reg freeze_active
);
    localparam ST_RUN = 2'b01;
    localparam ST_HOLD = 2'b10;

    reg [1:0] state;
    reg [7:0] value_r1;
    reg [7:0] value_lc;
    reg [7:0] value_r2;
    reg [7:0] fraction;
    reg [7:0] config5;
    reg [2:0] read_seen;
    reg rd_from_ram;
    reg [7:0] direct_data;
    reg [1:0] chan_q;
    reg [9:0] data_q;
    reg fault_q;
    reg valid_q;

    wire [71:0] ram_flat;
    wire [7:0] ram_rdata;
    wire twos_mode;
    wire is_ram_addr;
    wire [3:0] ram_idx;
    wire [3:0] rd_ram_idx;

    assign twos_mode = config5[`TRF_CFG5_TWOS_BIT];

    // map limit and correction register addresses onto store entries
    function [3:0] addr_to_idx;
        input [7:0] a;
        begin
            if (a >= `TRF_ADDR_R1_LOW && a <= `TRF_ADDR_R2_HIGH) begin
                addr_to_idx = a[3:0] - 4'he;
            end else if (a >= `TRF_ADDR_R1_CORR && a <= `TRF_ADDR_R2_CORR) begin
                addr_to_idx = a[3:0] + 4'd6;
            end else begin
                addr_to_idx = 4'hf;
            end
        end
    endfunction

    assign ram_idx = addr_to_idx(reg_addr);
    assign is_ram_addr = (ram_idx != 4'hf);
    assign rd_ram_idx = ram_idx;

    trf_regram u_ram (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(reg_wr && is_ram_addr),
        .wr_idx(ram_idx),
        .wr_data(reg_wdata),
        .rd_idx(rd_ram_idx),
        .rd_data(ram_rdata),
        .flat(ram_flat)
    );

    // measurement input registered (same clock domain)
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            chan_q <= 2'd0;
            data_q <= 10'd0;
            fault_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            chan_q <= meas_chan;
            data_q <= meas_data;
            fault_q <= meas_fault;
            valid_q <= meas_valid && meas_chan != 2'd3;
        end
    end

    // select correction and limits for the incoming channel
    reg [7:0] corr_sel;
    reg [7:0] low_sel;
    reg [7:0] high_sel;
    always @* begin
        corr_sel = ram_flat[(6 + chan_q) * 8 +: 8];
        low_sel = ram_flat[(chan_q * 2) * 8 +: 8];
        high_sel = ram_flat[(chan_q * 2 + 1) * 8 +: 8];
    end

    // correction: measurement is twos complement quarter degrees, correction
    // is half degrees so shifted left one before adding
    wire [11:0] meas_ext;
    wire [11:0] corr_ext;
    wire [11:0] sum;
    assign meas_ext = {{2{data_q[9]}}, data_q};
    assign corr_ext = {{3{corr_sel[7]}}, corr_sel, 1'b0};
    assign sum = meas_ext + corr_ext;

    // saturation limits as full-width words, cut to the 10-bit code below
    wire [11:0] lim_twos_floor;
    wire [11:0] lim_twos_max;
    wire [11:0] lim_off64_max;
    assign lim_twos_floor = `TRF_TWOS_FLOOR;
    assign lim_twos_max = `TRF_TWOS_MAX;
    assign lim_off64_max = `TRF_OFF64_MAX;

    // encode to the selected format with saturation and clamping
    reg [9:0] next_code;
    reg [11:0] biased;
    always @* begin
        next_code = 10'd0;
        biased = 12'd0;
        if (twos_mode) begin
            if (sum[11] && sum < `TRF_TWOS_FLOOR) begin
                next_code = lim_twos_floor[9:0];
            end else if (!sum[11] && sum > `TRF_TWOS_MAX) begin
                next_code = lim_twos_max[9:0];
            end else begin
                next_code = sum[9:0];
            end
        end else begin
            biased = sum + `TRF_OFF64_BIAS;
            if (biased[11]) begin
                next_code = 10'd0;
            end else if (biased > `TRF_OFF64_MAX) begin
                next_code = lim_off64_max[9:0];
            end else begin
                next_code = biased[9:0];
            end
        end
    end

    // fault code per mode
    wire [7:0] next_byte;
    wire [1:0] next_frac;
    assign next_byte = fault_q ? (twos_mode ? `TRF_FAULT_TWOS : `TRF_FAULT_OFF64)
                               : next_code[9:2];
    assign next_frac = fault_q ? 2'b00 : next_code[1:0];

    // limit compare in the active format
    wire cmp_high;
    wire cmp_low;
    assign cmp_high = twos_mode ? ($signed(next_byte) > $signed(high_sel))
                                : (next_byte > high_sel);
    assign cmp_low = twos_mode ? ($signed(next_byte) <= $signed(low_sel))
                               : (next_byte <= low_sel);

    // track which value bytes have been read during a freeze
    wire rd_fraction;
    wire [2:0] rd_value;
    assign rd_fraction = reg_rd && reg_addr == `TRF_ADDR_FRACTION;
    assign rd_value[0] = reg_rd && reg_addr == `TRF_ADDR_R1_VALUE;
    assign rd_value[1] = reg_rd && reg_addr == `TRF_ADDR_LC_VALUE;
    assign rd_value[2] = reg_rd && reg_addr == `TRF_ADDR_R2_VALUE;

    // freeze state machine
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_RUN;
            read_seen <= 3'b000;
        end else begin
            case (state)
                ST_RUN: begin
                    if (rd_fraction) begin
                        state <= ST_HOLD;
                        read_seen <= 3'b000;
                    end
                end
                ST_HOLD: begin
                    if ((read_seen | rd_value) == 3'b111) begin
                        state <= ST_RUN;
                        read_seen <= 3'b000;
                    end else begin
                        read_seen <= read_seen | rd_value;
                    end
                end
                default: begin
                    state <= ST_RUN;
                    read_seen <= 3'b000;
                end
            endcase
        end
    end

    // value and fraction update, held off while frozen
    wire can_update;
    assign can_update = valid_q && state == ST_RUN && !rd_fraction;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            value_r1 <= `TRF_RST_VALUE;
            value_lc <= `TRF_RST_VALUE;
            value_r2 <= `TRF_RST_VALUE;
            fraction <= `TRF_RST_FRACTION;
        end else if (can_update) begin
            case (chan_q)
                2'd0: begin
                    value_r1 <= next_byte;
                    fraction[`TRF_FRAC_R1_POS +: 2] <= next_frac;
                end
                2'd1: begin
                    value_lc <= next_byte;
                    fraction[`TRF_FRAC_LC_POS +: 2] <= next_frac;
                end
                2'd2: begin
                    value_r2 <= next_byte;
                    fraction[`TRF_FRAC_R2_POS +: 2] <= next_frac;
                end
                default: begin
                    value_r1 <= value_r1;
                end
            endcase
        end
    end

    // status reflects the last comparison on each channel
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            limit_status <= 3'b000;
        end else if (valid_q) begin
            limit_status[chan_q] <= cmp_high || cmp_low;
        end
    end

    // configuration register 5, only bit 1 is kept
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            config5 <= `TRF_RST_CONFIG5;
        end else if (reg_wr && reg_addr == `TRF_ADDR_CONFIG5) begin
            config5 <= {6'd0, reg_wdata[`TRF_CFG5_TWOS_BIT], 1'b0};
        end
    end

    // direct read data for registers outside the store
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            direct_data <= 8'h00;
            rd_from_ram <= 1'b0;
            reg_rvalid <= 1'b0;
        end else begin
            rd_from_ram <= is_ram_addr;
            reg_rvalid <= reg_rd;
            case (reg_addr)
                `TRF_ADDR_R1_VALUE: direct_data <= value_r1;
                `TRF_ADDR_LC_VALUE: direct_data <= value_lc;
                `TRF_ADDR_R2_VALUE: direct_data <= value_r2;
                `TRF_ADDR_FRACTION: direct_data <= fraction;
                `TRF_ADDR_CONFIG5: direct_data <= config5;
                default: direct_data <= 8'h00;
            endcase
        end
    end

    // output read data, one cycle after the stage above
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            freeze_active <= 1'b0;
        end else begin
            reg_rdata <= rd_from_ram ? ram_rdata : direct_data;
            freeze_active <= (state == ST_HOLD);
        end
    end
endmodule // trf_formatter

// File: trf_formatter_monitor.sv
module trf_formatter_monitor (
    input wire clk_sys,
    input wire rst_n,
    input wire meas_valid,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire [2:0] limit_status,
    input wire freeze_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // strobe for a read of the fraction register
    wire rd77 = reg_rd && reg_addr == 8'h77;
    sequence s_frac_rd;
        rd77;
    endsequence
    sequence s_hold;
        ##2 freeze_active [*2];
    endsequence
    AST_FREEZE_ON: assert property (s_frac_rd |-> s_hold)
        else $error("no hold after fraction read");
    AST_NO_FREEZE: assert property (!freeze_active && !rd77 && !$past(rd77) |=> !freeze_active)
        else $error("hold without fraction read");
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr < 8'h25 |-> ##2 reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CFG_BITS: assert property (reg_rd && reg_addr == 8'h7c |-> ##2 (reg_rdata & 8'hfd) == 8'h00)
        else $error("config read shows unused bits");
    AST_RST_OUT: assert property ($rose(rst_n) |-> reg_rdata == 8'h00 && !reg_rvalid && limit_status == 3'h0 && !freeze_active)
        else $error("outputs not cleared by reset");
    AST_STATUS_QUIET: assert property (!meas_valid && !$past(meas_valid) && !$past(meas_valid, 2) |=> $stable(limit_status))
        else $error("status moved without a sample");
endmodule // trf_formatter_monitor

bind trf_formatter trf_formatter_monitor u_trf_formatter_monitor (
    .clk_sys(clk_sys), .rst_n(rst_n), .meas_valid(meas_valid), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .limit_status(limit_status), .freeze_active(freeze_active)
);

// File: trf_host.sv
module trf_host (
    input wire clk_sys,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'hff;
    end
    // one-cycle write; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // one-cycle read; data taken one cycle after rvalid
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        n = 0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule // trf_host

// File: trf_formatter_bench.sv
module trf_formatter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_n, meas_valid, meas_fault;
    logic [1:0] meas_chan;
    logic [9:0] meas_data;
    wire reg_wr, reg_rd, reg_rvalid, freeze_active;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [2:0] limit_status;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    trf_formatter u_trf_formatter (.clk_sys(clk_sys), .rst_n(rst_n), .meas_chan(meas_chan),
        .meas_data(meas_data), .meas_valid(meas_valid), .meas_fault(meas_fault),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .limit_status(limit_status),
        .freeze_active(freeze_active));
    trf_host u_trf_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    task final_report;
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // read a register and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_trf_host.rd(a, d);
        chk($sformatf("reg_%h", a), d, e);
    endtask
    // one sample pulse, then let it land
    task automatic ms(input logic [1:0] c, input logic [9:0] v, input logic f);
        @(posedge clk_sys);
        meas_valid <= 1'b1;
        meas_chan <= c;
        meas_data <= v;
        meas_fault <= f;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        meas_data <= ~v;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset;
        rc(8'h77, 8'h00);
        for (int i = 0; i < 3; i++) rc(8'h25 + i[7:0], 8'h01);
        for (int i = 0; i < 6; i++) rc(8'h4e + i[7:0], i[0] ? 8'h7f : 8'h01);
        for (int i = 0; i < 3; i++) rc(8'h70 + i[7:0], 8'h00);
        u_trf_host.wr(8'h25, 8'h55);
        rc(8'h25, 8'h01);
        rc(8'h00, 8'h00);
        chk("freeze", {7'h00, freeze_active}, 8'h00);
    endtask
    task automatic t_off64;
        u_trf_host.wr(8'h71, 8'h04);
        ms(2'd1, 10'h066, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h00);
        rc(8'h77, 8'h20);
        chk("freeze", {7'h00, freeze_active}, 8'h01);
        rc(8'h26, 8'h5b);
        rc(8'h25, 8'h01);
        rc(8'h27, 8'h01);
    endtask
    task automatic t_freeze;
        rc(8'h77, 8'h20);
        ms(2'd0, 10'h000, 1'b0);
        rc(8'h25, 8'h01);
        rc(8'h26, 8'h5b);
        rc(8'h27, 8'h01);
        ms(2'd0, 10'h000, 1'b0);
        rc(8'h25, 8'h40);
    endtask
    task automatic t_sat;
        ms(2'd2, 10'h200, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h04);
        rc(8'h27, 8'h00);
        ms(2'd0, 10'h304, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h05);
        ms(2'd0, 10'h0fc, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h04);
        ms(2'd0, 10'h100, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h05);
        ms(2'd3, 10'h000, 1'b0);
        chk("status", {5'h00, limit_status}, 8'h05);
        rc(8'h25, 8'h80);
        ms(2'd1, 10'h066, 1'b1);
        rc(8'h26, 8'h00);
    endtask
    task automatic t_twos;
        u_trf_host.wr(8'h7c, 8'h02);
        rc(8'h7c, 8'h02);
        u_trf_host.wr(8'h4f, 8'h18);
        ms(2'd0, 10'h064, 1'b0);
        chk("status0", {7'h00, limit_status[0]}, 8'h01);
        rc(8'h25, 8'h19);
        ms(2'd0, 10'h060, 1'b0);
        chk("status0", {7'h00, limit_status[0]}, 8'h00);
        ms(2'd0, 10'h270, 1'b0);
        rc(8'h25, 8'hc1);
        u_trf_host.wr(8'h72, 8'h7f);
        ms(2'd2, 10'h1ff, 1'b0);
        ms(2'd1, 10'h000, 1'b1);
        rc(8'h77, 8'hc0);
        rc(8'h27, 8'h7f);
        rc(8'h26, 8'h80);
        rc(8'h25, 8'hc1);
    endtask
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report;
        end
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        meas_valid = 1'b0;
        meas_fault = 1'b0;
        meas_chan = 2'd0;
        meas_data = 10'h000;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_off64;
        t_freeze;
        t_sat;
        t_twos;
        final_report;
    end
endmodule // trf_formatter_bench
